// File: hw/flsu_top.sv
// field, logic and shift execution unit with character search
`include "flsu_params.svh"
module flsu_top #(
  parameter int W = `FLSU_WORD_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [5:0]   opcode,
  input  wire logic [11:0]  syllable,
  input  wire logic [W-1:0] opnd_a,
  input  wire logic [W-1:0] opnd_b,
  input  wire logic [W-1:0] aux_low_half_reg,
  input  wire logic [1:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_we,
  input  wire logic         reg_re,
  output logic [7:0]        reg_rdata,
  output logic              busy,
  output logic              done,
  output logic              illegal,
  output logic              branch_taken,
  output logic              dest_write,
  output logic              low_write,
  output logic [W-1:0]      res_word,
  output logic [W-1:0]      res_low
);
  flsu_pkg::flsu_state_t state_reg, state_next;
  flsu_pkg::flsu_op_t    op_reg;
  logic [W-1:0] a_reg, b_reg;
  logic [11:0]  syl_reg;
  logic [2:0]   char_count_reg, cnt_reg;
  logic [7:0]   rdata_reg;
  logic         done_reg, illegal_reg, branch_reg, dest_reg, low_reg, last_branch_reg;
  logic         busy_reg;
  logic [W-1:0] word_reg, low_out_reg;

  // command decode
  wire logic take = start && (state_reg == flsu_pkg::FLSU_ST_IDLE);
  wire flsu_pkg::flsu_op_t op_in = flsu_pkg::flsu_op_t'(opcode);
  wire logic in_word  = (opcode == flsu_pkg::FLSU_OP_WORD_INV) ||
                        (opcode == flsu_pkg::FLSU_OP_WORD_AND) ||
                        (opcode == flsu_pkg::FLSU_OP_WORD_OR) ||
                        (opcode == flsu_pkg::FLSU_OP_WORD_XOR);
  wire logic in_field = (opcode >= flsu_pkg::FLSU_OP_EXTR_ROT) &&
                        (opcode <= flsu_pkg::FLSU_OP_CMP_EQUAL) &&
                        (opcode != 6'h23);
  wire logic in_srch  = (opcode == flsu_pkg::FLSU_OP_SEARCH);
  wire logic in_shift = (opcode == flsu_pkg::FLSU_OP_SHIFT);
  wire logic in_legal = in_word || in_field || in_srch || in_shift;
  wire logic is_cmp   = (op_reg == flsu_pkg::FLSU_OP_CMP_EQUAL) ||
                        (op_reg == flsu_pkg::FLSU_OP_CMP_GREAT) ||
                        (op_reg == flsu_pkg::FLSU_OP_CMP_LESS);

  // field datapath
  logic [W-1:0] fld_res;
  logic         fld_hit;
  flsu_field #(.W(W)) u_field (
    .opa     (a_reg),
    .opb     (b_reg),
    .syl     (syl_reg),
    .op      (op_reg),
    .res     (fld_res),
    .cmp_hit (fld_hit)
  );

  // whole-word logic, sign bit included
  logic [W-1:0] word_res;
  always_comb
  begin
    case (op_reg)
      flsu_pkg::FLSU_OP_WORD_AND: word_res = a_reg & b_reg;
      flsu_pkg::FLSU_OP_WORD_OR:  word_res = a_reg | b_reg;
      flsu_pkg::FLSU_OP_WORD_XOR: word_res = a_reg ^ b_reg;
      default:                    word_res = ~a_reg;
    endcase
  end
  wire logic word_op = (op_reg == flsu_pkg::FLSU_OP_WORD_INV) ||
                       (op_reg == flsu_pkg::FLSU_OP_WORD_AND) ||
                       (op_reg == flsu_pkg::FLSU_OP_WORD_OR) ||
                       (op_reg == flsu_pkg::FLSU_OP_WORD_XOR);

  // shifter
  logic         sh_busy, sh_fin;
  logic [W-1:0] sh_hi, sh_lo;
  flsu_shift #(.W(W)) u_shift (
    .clk   (clk),
    .rst   (rst),
    .start (take && in_shift),
    .syl   (syllable),
    .src   (opnd_a),
    .aux   (aux_low_half_reg),
    .busy  (sh_busy),
    .fin   (sh_fin),
    .hi    (sh_hi),
    .lo    (sh_lo)
  );

  // character search step: decrement, examine, then test zero
  wire logic [2:0]   cnt_dec  = cnt_reg - 3'h1;
  wire logic [5:0]   shamt    = 6'(3'h7 - cnt_dec) * 6'h06;
  wire logic [W-1:0] shifted  = a_reg >> shamt;
  wire logic [5:0]   char_at  = shifted[5:0];
  wire logic         ch_match = (char_at == syl_reg[`FLSU_SRCH_CH_HI:`FLSU_SRCH_CH_LO]);
  wire logic         srch_end = ch_match || (cnt_dec == 3'h0);
  wire logic         in_srch_st = (state_reg == flsu_pkg::FLSU_ST_SEARCH);

  // register port decode
  wire logic sel_ccr   = (reg_addr == `FLSU_REG_CCR);
  wire logic sel_stat  = (reg_addr == `FLSU_REG_STAT);
  wire logic sw_ccr_wr = reg_we && sel_ccr;
  wire logic hw_ccr_wr = in_srch_st && srch_end;
  logic [7:0] stat_word;
  always_comb
  begin
    stat_word = 8'h00;
    stat_word[`FLSU_STAT_BUSY]   = (state_reg != flsu_pkg::FLSU_ST_IDLE);
    stat_word[`FLSU_STAT_BRANCH] = last_branch_reg;
  end
  wire logic [7:0] rd_mux = sel_ccr  ? {5'h00, char_count_reg} :
                            sel_stat ? stat_word : 8'h00;

  // state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      flsu_pkg::FLSU_ST_IDLE:
        if (take && in_legal)
          state_next = in_srch ? flsu_pkg::FLSU_ST_SEARCH :
                       in_shift ? flsu_pkg::FLSU_ST_SHIFT : flsu_pkg::FLSU_ST_EXEC;
      flsu_pkg::FLSU_ST_EXEC:
        state_next = flsu_pkg::FLSU_ST_IDLE;
      flsu_pkg::FLSU_ST_SEARCH:
        if (srch_end)
          state_next = flsu_pkg::FLSU_ST_IDLE;
      flsu_pkg::FLSU_ST_SHIFT:
        if (sh_fin)
          state_next = flsu_pkg::FLSU_ST_IDLE;
      default:
        state_next = flsu_pkg::FLSU_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= flsu_pkg::FLSU_ST_IDLE;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg  <= (state_next != flsu_pkg::FLSU_ST_IDLE);
    end
  end

  // operands are copied in; sources are never written back
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_reg <= '0; b_reg <= '0; syl_reg <= 12'h000;
      op_reg <= flsu_pkg::FLSU_OP_SHIFT;
    end
    else if (take)
    begin
      a_reg <= opnd_a; b_reg <= opnd_b;
      syl_reg <= syllable; op_reg <= op_in;
    end
  end

  // search counter and count register; search end wins over a software write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg        <= `FLSU_CCR_RST;
      char_count_reg <= `FLSU_CCR_RST;
    end
    else
    begin
      if (take && in_srch)
        cnt_reg <= char_count_reg;
      else if (in_srch_st)
        cnt_reg <= cnt_dec;
      if (hw_ccr_wr)
        char_count_reg <= ch_match ? cnt_dec : 3'h0;
      else if (sw_ccr_wr)
        char_count_reg <= reg_wdata[2:0];
    end
  end

  // completion outputs, each a one-cycle pulse except the result words
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_reg <= 1'b0; illegal_reg <= 1'b0; branch_reg <= 1'b0;
      dest_reg <= 1'b0; low_reg <= 1'b0; last_branch_reg <= 1'b0;
      word_reg <= '0; low_out_reg <= '0;
    end
    else
    begin
      done_reg    <= ((state_reg == flsu_pkg::FLSU_ST_EXEC) ||
                      (in_srch_st && srch_end) ||
                      (state_reg == flsu_pkg::FLSU_ST_SHIFT && sh_fin));
      illegal_reg <= take && !in_legal;
      branch_reg  <= 1'b0;
      dest_reg    <= 1'b0;
      low_reg     <= 1'b0;
      if (state_reg == flsu_pkg::FLSU_ST_EXEC)
      begin
        word_reg        <= word_op ? word_res : fld_res;
        dest_reg        <= !is_cmp;
        branch_reg      <= is_cmp && fld_hit;
        last_branch_reg <= is_cmp && fld_hit;
      end
      else if (in_srch_st && srch_end)
      begin
        branch_reg      <= ch_match;
        last_branch_reg <= ch_match;
      end
      else if (state_reg == flsu_pkg::FLSU_ST_SHIFT && sh_fin)
      begin
        word_reg        <= sh_hi;
        low_out_reg     <= sh_lo;
        dest_reg        <= 1'b1;
        low_reg         <= syl_reg[`FLSU_SH_DBL_BIT];
        last_branch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_re ? rd_mux : 8'h00;
  end

  assign reg_rdata    = rdata_reg;
  assign busy         = busy_reg;
  assign done         = done_reg;
  assign illegal      = illegal_reg;
  assign branch_taken = branch_reg;
  assign dest_write   = dest_reg;
  assign low_write    = low_reg;
  assign res_word     = word_reg;
  assign res_low      = low_out_reg;

  // checks
  property p_word_and;
    @(posedge clk) disable iff (rst)
    (state_reg == flsu_pkg::FLSU_ST_EXEC && op_reg == flsu_pkg::FLSU_OP_WORD_AND)
      |=> dest_write && res_word == ($past(a_reg) & $past(b_reg));
  endproperty
  a_word_and: assert property (p_word_and) else $error("word and result wrong");

  property p_word_inv;
    @(posedge clk) disable iff (rst)
    (take && opcode == flsu_pkg::FLSU_OP_WORD_INV) ##1 1'b1
      |=> done && res_word == ~$past(a_reg);
  endproperty
  a_word_inv: assert property (p_word_inv) else $error("word invert wrong");

  property p_cmp_no_dest;
    @(posedge clk) disable iff (rst)
    (state_reg == flsu_pkg::FLSU_ST_EXEC && is_cmp) |=> done && !dest_write;
  endproperty
  a_cmp_no_dest: assert property (p_cmp_no_dest) else $error("compare wrote a result");

  property p_cmp_branch;
    @(posedge clk) disable iff (rst)
    (state_reg == flsu_pkg::FLSU_ST_EXEC && op_reg == flsu_pkg::FLSU_OP_CMP_EQUAL &&
     fld_res == b_reg) |=> branch_taken;
  endproperty
  a_cmp_branch: assert property (p_cmp_branch) else $error("equal compare missed");

  property p_srch_bound;
    @(posedge clk) disable iff (rst)
    (take && in_srch) |=> in_srch_st ##[1:8] done;
  endproperty
  a_srch_bound: assert property (p_srch_bound) else $error("search overran");

  property p_srch_miss;
    @(posedge clk) disable iff (rst)
    (in_srch_st && srch_end && !ch_match) |=> !branch_taken && char_count_reg == 3'h0;
  endproperty
  a_srch_miss: assert property (p_srch_miss) else $error("miss left count set");

  property p_srch_hit;
    @(posedge clk) disable iff (rst)
    (in_srch_st && ch_match) |=> branch_taken && char_count_reg == $past(cnt_dec);
  endproperty
  a_srch_hit: assert property (p_srch_hit) else $error("hit position lost");

  property p_left_steps;
    @(posedge clk) disable iff (rst)
    (take && in_shift && !syllable[`FLSU_SH_RGT_BIT] && syllable[5:0] == 6'h04)
      |=> sh_busy[*5] ##1 !sh_busy;
  endproperty
  a_left_steps: assert property (p_left_steps) else $error("left shift step count");

  property p_right_big;
    @(posedge clk) disable iff (rst)
    (take && in_shift && syllable[`FLSU_SH_RGT_BIT] && syllable[5:0] == 6'h0C)
      |=> sh_busy[*2] ##1 !sh_busy;
  endproperty
  a_right_big: assert property (p_right_big) else $error("right 12 not one step");

  property p_sgl_log_left;
    @(posedge clk) disable iff (rst)
    (take && syllable[11:6] == 6'h03 && syllable[5:0] == 6'h01 && in_shift)
      |=> ##3 dest_write && res_word == ($past(opnd_a, 4) << 1);
  endproperty
  a_sgl_log_left: assert property (p_sgl_log_left) else $error("end-off left wrong");

  c_field_sub: cover property (@(posedge clk) state_reg == flsu_pkg::FLSU_ST_EXEC &&
                               op_reg == flsu_pkg::FLSU_OP_FLD_SUB);
  c_srch_hit:  cover property (@(posedge clk) in_srch_st && ch_match);
  c_dbl_shift: cover property (@(posedge clk) low_write);
  c_cmp_taken: cover property (@(posedge clk) is_cmp && branch_taken);
endmodule : flsu_top

// File: hw/flsu_params.svh
// constants for the field, logic and shift unit
`ifndef FLSU_PARAMS_SVH
`define FLSU_PARAMS_SVH
`define FLSU_WORD_W      48
`define FLSU_CHAR_W      6
`define FLSU_SYL_W       12
`define FLSU_FLD_LEN_HI  6
`define FLSU_FLD_LEN_LO  4
`define FLSU_FLD_POS_HI  2
`define FLSU_FLD_POS_LO  0
`define FLSU_FLD_ADJ_HI  10
`define FLSU_FLD_ADJ_LO  8
`define FLSU_SH_DBL_BIT  9
`define FLSU_SH_RGT_BIT  8
`define FLSU_SH_LOG_BIT  7
`define FLSU_SH_EOF_BIT  6
`define FLSU_SH_AMT_HI   5
`define FLSU_SH_AMT_LO   0
`define FLSU_SRCH_CH_HI  5
`define FLSU_SRCH_CH_LO  0
`define FLSU_SH_BIG_STEP 7'h0C
`define FLSU_SH_MID_STEP 7'h06
`define FLSU_REG_CCR     2'h0
`define FLSU_REG_STAT    2'h1
`define FLSU_CCR_RST     3'h0
`define FLSU_STAT_BUSY   0
`define FLSU_STAT_BRANCH 1
`endif

// File: hw/flsu_pkg.sv
// operation codes and state types of the field, logic and shift unit
package flsu_pkg;
  typedef enum logic [5:0] {
    FLSU_OP_WORD_INV  = 6'h14,
    FLSU_OP_SEARCH    = 6'h1A,
    FLSU_OP_EXTR_ROT  = 6'h21,
    FLSU_OP_FLD_SUB   = 6'h22,
    FLSU_OP_FLD_OR    = 6'h24,
    FLSU_OP_FLD_XOR   = 6'h25,
    FLSU_OP_FLD_INV   = 6'h26,
    FLSU_OP_FLD_AND   = 6'h27,
    FLSU_OP_CMP_LESS  = 6'h28,
    FLSU_OP_CMP_GREAT = 6'h29,
    FLSU_OP_CMP_EQUAL = 6'h2A,
    FLSU_OP_WORD_XOR  = 6'h2C,
    FLSU_OP_WORD_OR   = 6'h2D,
    FLSU_OP_WORD_AND  = 6'h2E,
    FLSU_OP_SHIFT     = 6'h30
  } flsu_op_t;
  typedef enum logic [1:0] {
    FLSU_ST_IDLE   = 2'b00,
    FLSU_ST_EXEC   = 2'b01,
    FLSU_ST_SEARCH = 2'b11,
    FLSU_ST_SHIFT  = 2'b10
  } flsu_state_t;
endpackage : flsu_pkg

// File: hw/flsu_field.sv
// combinational partial-word datapath: strip, combine, merge, rotate, compare
`include "flsu_params.svh"
module flsu_field #(
  parameter int W = `FLSU_WORD_W
) (
  input  wire logic [W-1:0]           opa,
  input  wire logic [W-1:0]           opb,
  input  wire logic [11:0]            syl,
  input  wire flsu_pkg::flsu_op_t     op,
  output logic      [W-1:0]           res,
  output logic                        cmp_hit
);
  localparam int NCH = W / `FLSU_CHAR_W;
  wire logic [3:0]   len  = (syl[`FLSU_FLD_LEN_HI:`FLSU_FLD_LEN_LO] == 3'h0) ? 4'h8 :
                            {1'b0, syl[`FLSU_FLD_LEN_HI:`FLSU_FLD_LEN_LO]};
  wire logic [3:0]   pos  = {1'b0, syl[`FLSU_FLD_POS_HI:`FLSU_FLD_POS_LO]};
  wire logic [2:0]   adj  = syl[`FLSU_FLD_ADJ_HI:`FLSU_FLD_ADJ_LO];
  wire logic [W-1:0] mask;
  // character 0 is the leftmost; a field running past 7 is clipped
  for (genvar c = 0; c < NCH; c++)
  begin : g_mask
    assign mask[W-1-c*`FLSU_CHAR_W -: `FLSU_CHAR_W] =
      {`FLSU_CHAR_W{(4'(c) >= pos) && (4'(c) < pos + len)}};
  end
  wire logic [W-1:0] ea   = opa & mask;
  wire logic [W-1:0] eb   = opb & mask;
  wire logic [W-1:0] diff = (ea >= eb) ? ea - eb : eb - ea;
  logic      [W-1:0] comb;
  always_comb
  begin
    case (op)
      flsu_pkg::FLSU_OP_FLD_SUB: comb = diff;
      flsu_pkg::FLSU_OP_FLD_AND: comb = ea & eb;
      flsu_pkg::FLSU_OP_FLD_OR:  comb = ea | eb;
      flsu_pkg::FLSU_OP_FLD_XOR: comb = ea ^ eb;
      flsu_pkg::FLSU_OP_FLD_INV: comb = ~ea;
      default:                   comb = ea;
    endcase
  end
  // re-strip, clear field in first operand, merge
  wire logic [W-1:0]   merged = (comb & mask) | (opa & ~mask);
  wire logic           strip  = (op == flsu_pkg::FLSU_OP_EXTR_ROT) ||
                                (op == flsu_pkg::FLSU_OP_CMP_EQUAL) ||
                                (op == flsu_pkg::FLSU_OP_CMP_GREAT) ||
                                (op == flsu_pkg::FLSU_OP_CMP_LESS);
  wire logic [W-1:0]   pre    = strip ? ea : merged;
  // right end-around by whole characters
  wire logic [2*W-1:0] dbl    = {pre, pre} >> (6'(adj) * 6'h06);
  assign res = dbl[W-1:0];
  // full-width unsigned compare, stack top taken as isolated
  always_comb
  begin
    case (op)
      flsu_pkg::FLSU_OP_CMP_EQUAL: cmp_hit = (res == opb);
      flsu_pkg::FLSU_OP_CMP_GREAT: cmp_hit = (res > opb);
      flsu_pkg::FLSU_OP_CMP_LESS:  cmp_hit = (res < opb);
      default:                     cmp_hit = 1'b0;
    endcase
  end
endmodule : flsu_field

// File: hw/flsu_shift.sv
// stepping shifter for single and double shifts
`include "flsu_params.svh"
module flsu_shift #(
  parameter int W = `FLSU_WORD_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [11:0]  syl,
  input  wire logic [W-1:0] src,
  input  wire logic [W-1:0] aux,
  output logic              busy,
  output logic              fin,
  output logic [W-1:0]      hi,
  output logic [W-1:0]      lo
);
  logic [2*W-1:0] work_reg, work_next;
  logic [6:0]     wid_reg;
  logic [5:0]     rem_reg;
  logic           rgt_reg, eof_reg, dbl_reg, log_reg, busy_reg, fin_reg;
  logic           sgn_hi_reg, sgn_lo_reg;
  // bits 2..48 only for arithmetic, halves joined when double
  wire logic [6:0] wid_ld = syl[`FLSU_SH_DBL_BIT] ?
                            (syl[`FLSU_SH_LOG_BIT] ? 7'h60 : 7'h5E) :
                            (syl[`FLSU_SH_LOG_BIT] ? 7'h30 : 7'h2F);
  wire logic [2*W-1:0] ld_val = !syl[`FLSU_SH_DBL_BIT] ?
    (syl[`FLSU_SH_LOG_BIT] ? {48'h0, src} : {49'h0, src[W-2:0]}) :
    (syl[`FLSU_SH_LOG_BIT] ? {src, aux} : {2'h0, src[W-2:0], aux[W-2:0]});
  // left one bit per step; right greedily by 12, 6, then 1
  wire logic [6:0] step = !rgt_reg ? 7'h01 :
                          ({1'b0, rem_reg} >= `FLSU_SH_BIG_STEP) ? `FLSU_SH_BIG_STEP :
                          ({1'b0, rem_reg} >= `FLSU_SH_MID_STEP) ? `FLSU_SH_MID_STEP : 7'h01;
  wire logic [2*W-1:0] wmask = ~({2*W{1'b1}} << wid_reg);
  wire logic [2*W-1:0] sl    = (work_reg << step) & wmask;
  wire logic [2*W-1:0] sr    = work_reg >> step;
  wire logic [2*W-1:0] out_l = (work_reg >> (wid_reg - step)) & wmask;
  wire logic [2*W-1:0] out_r = (work_reg << (wid_reg - step)) & wmask;
  // end-off drops bits and zero fills; end-around wraps them
  assign work_next = rgt_reg ? (eof_reg ? sr : sr | out_r) : (eof_reg ? sl : sl | out_l);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      work_reg <= '0; wid_reg <= 7'h0; rem_reg <= 6'h0; busy_reg <= 1'b0; fin_reg <= 1'b0;
      rgt_reg <= 1'b0; eof_reg <= 1'b0; dbl_reg <= 1'b0; log_reg <= 1'b0;
      sgn_hi_reg <= 1'b0; sgn_lo_reg <= 1'b0;
    end
    else if (start && !busy_reg)
    begin
      work_reg <= ld_val; wid_reg <= wid_ld; busy_reg <= 1'b1; fin_reg <= 1'b0;
      rem_reg <= syl[`FLSU_SH_AMT_HI:`FLSU_SH_AMT_LO];
      rgt_reg <= syl[`FLSU_SH_RGT_BIT]; eof_reg <= syl[`FLSU_SH_EOF_BIT];
      dbl_reg <= syl[`FLSU_SH_DBL_BIT]; log_reg <= syl[`FLSU_SH_LOG_BIT];
      sgn_hi_reg <= src[W-1]; sgn_lo_reg <= aux[W-1];
    end
    else if (busy_reg)
    begin
      fin_reg <= (rem_reg == 6'h0);
      busy_reg <= (rem_reg != 6'h0);
      if (rem_reg != 6'h0)
      begin
        work_reg <= work_next;
        rem_reg  <= rem_reg - step[5:0];
      end
    end
    else
      fin_reg <= 1'b0;
  end
  assign busy = busy_reg;
  assign fin  = fin_reg;
  // sign bits stay put for arithmetic shifts
  assign hi = !dbl_reg ? (log_reg ? work_reg[W-1:0] : {sgn_hi_reg, work_reg[W-2:0]}) :
              (log_reg ? work_reg[2*W-1:W] : {sgn_hi_reg, work_reg[2*W-3:W-1]});
  assign lo = log_reg ? work_reg[W-1:0] : {sgn_lo_reg, work_reg[W-2:0]};
endmodule : flsu_shift

// File: testbench/flsu_top_test.sv
// self-checking bench for the field, logic and shift unit
module flsu_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, start, reg_we, reg_re, busy, done, illegal;
  logic        branch_taken, dest_write, low_write;
  logic [5:0]  opcode;
  logic [11:0] syllable;
  logic [47:0] opnd_a, opnd_b, aux, res_word, res_low, e;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [3:0]  flg;
  int          error_cnt, check_count;
  logic [5:0]  fops [6] = '{6'h22, 6'h27, 6'h24, 6'h25, 6'h26, 6'h21};
  logic [11:0] fsyl [3] = '{12'h242, 12'h300, 12'h414};
  logic [5:0]  cops [3] = '{6'h28, 6'h29, 6'h2A};
  int          jt [3] = '{1, -1, 0};
  logic [11:0] ssyl [7] = '{12'h084, 12'h041, 12'h1CD, 12'h186, 12'h2C4, 12'h0C1, 12'h18C};
  logic [47:0] sa [7] = '{48'h800000000001, 48'hC00000000001, 48'hFFFFFFFFFFFF,
                          48'h0000000000AB, 48'h000000000001, 48'h800000000003,
                          48'h000000000ABC};
  logic [47:0] sx [7] = '{48'h000000000018, 48'h800000000002, 48'h0007FFFFFFFF,
                          48'hAC0000000002, 48'h00000000001F, 48'h000000000006,
                          48'hABC000000000};
  flsu_top u_flsu_top (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
    .syllable(syllable), .opnd_a(opnd_a), .opnd_b(opnd_b), .aux_low_half_reg(aux),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .busy(busy), .done(done), .illegal(illegal),
    .branch_taken(branch_taken), .dest_write(dest_write), .low_write(low_write),
    .res_word(res_word), .res_low(res_low));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // field model: strip, combine, re-strip, merge, rotate right by characters
  function automatic logic [47:0] fexp(input logic [5:0] o, input logic [11:0] s,
                                       input logic [47:0] a, input logic [47:0] b);
    logic [47:0] m, fa, fb, r;
    logic [95:0] d;
    int          len;
    len = (s[6:4] == 3'h0) ? 8 : int'(s[6:4]);
    m = '0;
    for (int i = 0; i < 8; i++)
      if (i >= s[2:0] && i < s[2:0] + len) m[47-6*i -: 6] = 6'h3F;
    fa = a & m;
    fb = b & m;
    case (o)
      6'h22: r = (fa > fb) ? fa - fb : fb - fa;
      6'h27: r = fa & fb;
      6'h24: r = fa | fb;
      6'h25: r = fa ^ fb;
      6'h26: r = ~fa;
      default: r = fa;
    endcase
    r = r & m;
    if (o != 6'h21) r = r | (a & ~m);
    d = {r, r} >> (6 * s[10:8]);
    return d[47:0];
  endfunction : fexp
  task automatic run(input logic [5:0] o, input logic [11:0] s,
                     input logic [47:0] a, input logic [47:0] b);
    int n;
    @(posedge clk);
    start    <= 1'b1;
    opcode   <= o;
    syllable <= s;
    opnd_a   <= a;
    opnd_b   <= b;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    #1;
    chk({47'h0, busy}, {47'h0, o != 6'h23});
    while (done !== 1'b1 && illegal !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    flg = {illegal, branch_taken, dest_write, low_write};
    chk(48'(n / 40), 48'h0);
  endtask : run
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk({40'h0, reg_rdata}, {40'h0, exp});
  endtask : rd
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    {rst, start, reg_we, reg_re, opcode, syllable, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    {opnd_a, opnd_b, aux, error_cnt, check_count} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h05);
    rd(2'h0, 8'h05);
    run(6'h2E, 12'h000, 48'hC3A55A3C0F0F, 48'h8F0FF00F33CC);
    chk(res_word, 48'h8305500C030C);
    chk({44'h0, flg}, 48'h2);
    run(6'h2D, 12'h000, 48'hC3A55A3C0F0F, 48'h8F0FF00F33CC);
    chk(res_word, 48'hCFAFFA3F3FCF);
    run(6'h2C, 12'h000, 48'hC3A55A3C0F0F, 48'h8F0FF00F33CC);
    chk(res_word, 48'h4CAAAA333CC3);
    run(6'h14, 12'h000, 48'hC3A55A3C0F0F, 48'h0);
    chk(res_word, 48'h3C5AA5C3F0F0);
    foreach (fsyl[k])
      foreach (fops[i])
      begin
        run(fops[i], fsyl[k], 48'h0123456789AB, 48'hFEDCBA987654);
        chk(res_word, fexp(fops[i], fsyl[k], 48'h0123456789AB, 48'hFEDCBA987654));
        chk({44'h0, flg}, 48'h2);
      end
    e = fexp(6'h21, 12'h635, 48'hFFFFFFFFFFFF, 48'h0);
    foreach (cops[k])
      for (int j = -1; j < 2; j++)
      begin
        run(cops[k], 12'h635, 48'hFFFFFFFFFFFF, e + 48'(j));
        chk({46'h0, flg[2:1]}, {46'h0, j == jt[k], 1'b0});
      end
    wr(2'h0, 8'h00);
    foreach (jt[k])
    begin
      run(6'h1A, 12'h02E, 48'h000B80000B80, 48'h0);
      chk({47'h0, flg[2]}, {47'h0, k < 2});
      rd(2'h0, (k == 0) ? 8'h06 : (k == 1) ? 8'h02 : 8'h00);
      rd(2'h1, (k < 2) ? 8'h02 : 8'h00);
    end
    aux <= 48'hF00000000001;  // double amount 4 stays in range
    foreach (ssyl[k])
    begin
      run(6'h30, ssyl[k], sa[k], 48'h0);
      chk(res_word, sx[k]);
      chk({47'h0, flg[0]}, {47'h0, k == 4});
      if (k == 4) chk(res_low, 48'h000000000010);
    end
    run(6'h23, 12'h000, 48'h0, 48'h0);
    chk({44'h0, flg}, 48'h8);
    wrap_up();
  end
endmodule : flsu_top_test
